// *** shared/mpe_pkg.sv ***
/*
 * mpe_pkg: shared constants for the motor pwm and encoder count block.
 * assumes a single 20 MHz peripheral clock and 16-bit timer registers.
 */
`default_nettype none
package mpe_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] ZERO_VAL = 16'h0000;
    localparam logic [15:0] ONE_VAL = 16'h0001;
    localparam logic [15:0] MAX_VAL = 16'hffff;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CYCLE_RST = 16'hffff;
    localparam logic [15:0] HALF_RST = 16'h7fff;
    localparam logic [15:0] DEAD_RST = 16'h0001;
    localparam logic [15:0] DUTY_RST = 16'h0000;
    localparam int ACCESS_ENABLE_POS = 0;
    localparam logic [7:0] PROTECT_RST = 8'h01;
    typedef enum logic [1:0] {
        MPE_MODE_NORMAL,
        MPE_MODE_RESET_SYNC,
        MPE_MODE_COMPL
    } mpe_mode_t;
endpackage
`default_nettype wire

// *** core/mpe_quad_counter.sv ***
/*
 * mpe_quad_counter: quadrature count mode 4 counter for one encoder channel.
 * assumes raw encoder pins, asynchronous to i_clk, on the two phase inputs.
 */
`default_nettype none
module mpe_quad_counter #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_enc_a,
    input wire logic i_enc_b,
    input wire logic i_ovf_clr,
    input wire logic i_unf_clr,
    output logic [WIDTH-1:0] o_count,
    output logic o_count_clk,
    output logic o_overflow_flag,
    output logic o_underflow_flag
);
    initial begin
        if (WIDTH < 2) $error("width too small");
    end

    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic b_prev;
    logic [WIDTH-1:0] count;
    logic ovf;
    logic unf;
    logic pulse;
    logic [1:0] next_a_sync;
    logic [1:0] next_b_sync;
    logic next_b_prev;
    logic [WIDTH-1:0] next_count;
    logic next_ovf;
    logic next_unf;
    logic next_pulse;
    logic b_rise;
    logic b_fall;
    logic up;
    logic down;

    always_comb begin
        // second stage only is looked at; first stage feeds nothing else
        next_a_sync = {a_sync[0], i_enc_a};
        next_b_sync = {b_sync[0], i_enc_b};
        next_b_prev = b_sync[1];
        b_rise = b_sync[1] & ~b_prev;
        b_fall = ~b_sync[1] & b_prev;
        // a edges never count in this mode
        up = (a_sync[1] & b_fall) | (~a_sync[1] & b_rise);
        down = (a_sync[1] & b_rise) | (~a_sync[1] & b_fall);
        next_count = count;
        next_pulse = up | down;
        next_ovf = ovf & ~i_ovf_clr;
        next_unf = unf & ~i_unf_clr;
        if (up) begin
            next_count = count + 1'b1;
            if (&count) next_ovf = 1'b1;
        end else if (down) begin
            next_count = count - 1'b1;
            if (count == '0) next_unf = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            a_sync <= 2'h0;
            b_sync <= 2'h0;
            b_prev <= 1'b0;
            count <= '0;
            ovf <= 1'b0;
            unf <= 1'b0;
            pulse <= 1'b0;
        end else if (i_ce) begin
            a_sync <= next_a_sync;
            b_sync <= next_b_sync;
            b_prev <= next_b_prev;
            count <= next_count;
            ovf <= next_ovf;
            unf <= next_unf;
            pulse <= next_pulse;
        end
    end

    assign o_count = count;
    assign o_count_clk = pulse;
    assign o_overflow_flag = ovf;
    assign o_underflow_flag = unf;

    property p_ovf_set;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && up && (&count)) |=> ovf;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow lost");

    property p_a_only;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && b_sync[1] == b_prev) |=> $stable(count);
    endproperty
    a_a_only: assert property (p_a_only) else $error("count moved on a");
endmodule
`default_nettype wire

// *** core/mpe_motor_timer.sv ***
/*
 * mpe_motor_timer: encoder count with capture coupling, reset-synchronized
 * and complementary pwm on the two motor channels.
 * assumes software drives the register write ports on i_clk and keeps
 * counters zero before starting reset-synchronized pwm.
 */
`default_nettype none
module mpe_motor_timer (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_enc_a_in_ch1,
    input wire logic i_enc_b_in_ch1,
    input wire logic i_ovf_clr,
    input wire logic i_unf_clr,
    input wire logic [15:0] i_speed_period_compare,
    input wire logic [15:0] i_position_period_compare,
    input wire logic i_capture_on_count_clk,
    input wire logic i_capture_buffer_mode,
    input wire mpe_pkg::mpe_mode_t i_mode,
    input wire logic i_start,
    input wire logic i_period_toggle_en,
    input wire logic i_dead_time_en,
    input wire logic [7:0] i_write_protect_wdata,
    input wire logic i_write_protect_we,
    input wire logic [15:0] i_wdata,
    input wire logic i_cnt_a_we,
    input wire logic i_cnt_b_we,
    input wire logic i_cycle_limit_we,
    input wire logic i_phase1_we,
    input wire logic i_phase2_we,
    input wire logic i_phase3_we,
    input wire logic i_deadtime_we,
    input wire logic i_half_cycle_we,
    input wire logic i_cycle_buf_we,
    input wire logic i_phase1_buf_we,
    input wire logic i_phase2_buf_we,
    input wire logic i_phase3_buf_we,
    input wire logic i_half_buf_we,
    output logic [15:0] o_up_down_counter,
    output logic o_overflow_flag,
    output logic o_underflow_flag,
    output logic [15:0] o_pulse_width_capture,
    output logic [15:0] o_pulse_width_capture_buffer,
    output logic [15:0] o_count_snapshot_a,
    output logic [15:0] o_count_snapshot_b,
    output logic [15:0] o_carrier_counter_a,
    output logic [15:0] o_carrier_counter_b,
    output logic [15:0] o_deadtime_subcounter,
    output logic [15:0] o_cycle_limit_reg,
    output logic [15:0] o_phase1_compare,
    output logic [15:0] o_phase2_compare,
    output logic [15:0] o_phase3_compare,
    output logic [15:0] o_deadtime_value,
    output logic [15:0] o_half_cycle_value,
    output logic [15:0] o_cycle_limit_buffer,
    output logic [15:0] o_phase1_buffer,
    output logic [15:0] o_phase2_buffer,
    output logic [15:0] o_phase3_buffer,
    output logic [15:0] o_half_cycle_buffer,
    output logic [7:0] o_write_protect_reg,
    output logic o_pwm_pins_active,
    output logic o_period_toggle_out,
    output logic o_period_toggle_active,
    output logic o_pwm1_pos_out,
    output logic o_pwm1_neg_out,
    output logic o_pwm2_pos_out,
    output logic o_pwm2_neg_out,
    output logic o_pwm3_pos_out,
    output logic o_pwm3_neg_out
);
    logic [15:0] enc_count;
    logic enc_clk;
    mpe_quad_counter #(.WIDTH(mpe_pkg::CNT_W)) u_quad (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_enc_a(i_enc_a_in_ch1),
        .i_enc_b(i_enc_b_in_ch1),
        .i_ovf_clr(i_ovf_clr),
        .i_unf_clr(i_unf_clr),
        .o_count(enc_count),
        .o_count_clk(enc_clk),
        .o_overflow_flag(o_overflow_flag),
        .o_underflow_flag(o_underflow_flag)
    );

    // capture channel: free-running period counter, cleared by position match
    logic [15:0] per_cnt, pw_cnt, pw_cap, pw_buf, snap_a, snap_b;
    logic [15:0] next_per_cnt, next_pw_cnt, next_pw_cap, next_pw_buf;
    logic [15:0] next_snap_a, next_snap_b;
    logic spd_match, pos_match;

    always_comb begin
        spd_match = per_cnt == i_speed_period_compare;
        pos_match = per_cnt == i_position_period_compare;
        next_per_cnt = pos_match ? mpe_pkg::ZERO_VAL : per_cnt + 1'b1;
        next_pw_cnt = pw_cnt + 1'b1;
        next_pw_cap = pw_cap;
        next_pw_buf = pw_buf;
        next_snap_a = spd_match ? enc_count : snap_a;
        next_snap_b = pos_match ? enc_count : snap_b;
        if (i_capture_on_count_clk && enc_clk) begin
            next_pw_cap = pw_cnt;
            next_pw_cnt = mpe_pkg::ZERO_VAL;
            if (i_capture_buffer_mode) next_pw_buf = pw_cap;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            per_cnt <= mpe_pkg::CNT_RST;
            pw_cnt <= mpe_pkg::CNT_RST;
            pw_cap <= mpe_pkg::CNT_RST;
            pw_buf <= mpe_pkg::CNT_RST;
            snap_a <= mpe_pkg::CNT_RST;
            snap_b <= mpe_pkg::CNT_RST;
        end else if (i_ce) begin
            per_cnt <= next_per_cnt;
            pw_cnt <= next_pw_cnt;
            pw_cap <= next_pw_cap;
            pw_buf <= next_pw_buf;
            snap_a <= next_snap_a;
            snap_b <= next_snap_b;
        end
    end

    // motor channels
    logic [15:0] cnt_a, cnt_b, sub_cnt, cyc, ph1, ph2, ph3, dead, half;
    logic [15:0] cyc_buf, ph1_buf, ph2_buf, ph3_buf, half_buf;
    logic [15:0] stg1, stg2, stg3;
    logic [7:0] prot;
    logic dir_a_down, dir_b_down, tog, p1, p2, p3;
    mpe_pkg::mpe_mode_t mode_q;
    logic [15:0] next_cnt_a, next_cnt_b, next_sub_cnt, next_cyc;
    logic [15:0] next_ph1, next_ph2, next_ph3, next_dead, next_half;
    logic [15:0] next_cyc_buf, next_ph1_buf, next_ph2_buf, next_ph3_buf;
    logic [15:0] next_half_buf, next_stg1, next_stg2, next_stg3;
    logic [7:0] next_prot;
    logic next_dir_a_down, next_dir_b_down, next_tog;
    logic next_p1, next_p2, next_p3;
    logic wr_ok, rs, cp, enter_cp, clr_a;
    logic [15:0] cmp_cnt;
    logic m1, m2, m3;

    always_comb begin
        wr_ok = prot[mpe_pkg::ACCESS_ENABLE_POS];
        rs = i_mode == mpe_pkg::MPE_MODE_RESET_SYNC;
        cp = i_mode == mpe_pkg::MPE_MODE_COMPL;
        enter_cp = cp && (mode_q != mpe_pkg::MPE_MODE_COMPL);
        next_prot = i_write_protect_we ? i_write_protect_wdata : prot;
        // buffers take writes regardless of protection
        next_cyc_buf = i_cycle_buf_we ? i_wdata : cyc_buf;
        next_ph1_buf = i_phase1_buf_we ? i_wdata : ph1_buf;
        next_ph2_buf = i_phase2_buf_we ? i_wdata : ph2_buf;
        next_ph3_buf = i_phase3_buf_we ? i_wdata : ph3_buf;
        next_half_buf = i_half_buf_we ? i_wdata : half_buf;
        // staging follows buffers; no cpu port reaches it
        next_stg1 = ph1_buf;
        next_stg2 = ph2_buf;
        next_stg3 = ph3_buf;
        next_cyc = (i_cycle_limit_we && wr_ok) ? i_wdata : cyc;
        next_ph1 = (i_phase1_we && wr_ok) ? i_wdata : ph1;
        next_ph2 = (i_phase2_we && wr_ok) ? i_wdata : ph2;
        next_ph3 = (i_phase3_we && wr_ok) ? i_wdata : ph3;
        next_dead = (i_deadtime_we && wr_ok) ? i_wdata : dead;
        next_half = (i_half_cycle_we && wr_ok) ? i_wdata : half;
        next_cnt_a = (i_cnt_a_we && wr_ok) ? i_wdata : cnt_a;
        next_cnt_b = (i_cnt_b_we && wr_ok) ? i_wdata : cnt_b;
        next_sub_cnt = sub_cnt;
        next_dir_a_down = dir_a_down;
        next_dir_b_down = dir_b_down;
        next_tog = tog;
        next_p1 = p1;
        next_p2 = p2;
        next_p3 = p3;
        clr_a = 1'b0;
        // the dead time subcounter tracks a with the a-b offset removed
        cmp_cnt = cnt_b;
        m1 = cmp_cnt == ph1;
        m2 = cmp_cnt == ph2;
        m3 = cmp_cnt == ph3;
        if (enter_cp) begin
            // dead time register itself is not a buffered value
            next_cyc = cyc_buf;
            next_half = half_buf;
            next_ph1 = ph1_buf;
            next_ph2 = ph2_buf;
            next_ph3 = ph3_buf;
            next_stg1 = ph1_buf;
            next_stg2 = ph2_buf;
            next_stg3 = ph3_buf;
            next_cnt_a = dead;
            next_cnt_b = mpe_pkg::ZERO_VAL;
            next_sub_cnt = mpe_pkg::ZERO_VAL;
            next_dir_a_down = 1'b0;
            next_dir_b_down = 1'b0;
            next_p1 = 1'b0;
            next_p2 = 1'b0;
            next_p3 = 1'b0;
        end else if (rs && i_start) begin
            m1 = cnt_a == ph1;
            m2 = cnt_a == ph2;
            m3 = cnt_a == ph3;
            clr_a = cnt_a == cyc;
            // up-only sawtooth, cleared on cycle limit
            next_cnt_a = clr_a ? mpe_pkg::ZERO_VAL : cnt_a + 1'b1;
            next_cnt_b = clr_a ? mpe_pkg::ZERO_VAL : cnt_b + 1'b1;
            // toggle on each phase match and on every clear
            next_p1 = p1 ^ (m1 | clr_a);
            next_p2 = p2 ^ (m2 | clr_a);
            next_p3 = p3 ^ (m3 | clr_a);
        end else if (cp && i_start) begin
            if (!dir_a_down) begin
                next_cnt_a = cnt_a + 1'b1;
                if (cnt_a + 1'b1 == cyc) next_dir_a_down = 1'b1;
            end else begin
                next_cnt_a = cnt_a - 1'b1;
                if (cnt_a - 1'b1 == dead) next_dir_a_down = 1'b0;
            end
            if (!dir_b_down) begin
                next_cnt_b = cnt_b + 1'b1;
                if (cnt_b + 1'b1 == half) next_dir_b_down = 1'b1;
            end else begin
                next_cnt_b = cnt_b - 1'b1;
                if (cnt_b == mpe_pkg::ONE_VAL) next_dir_b_down = 1'b0;
            end
            next_sub_cnt = cnt_a - dead;
            // the turn flag clears on the step into the trough, so the
            // trough is caught on that step rather than after it
            if (dir_a_down && (cnt_a - 1'b1 == dead)) begin
                next_tog = ~tog;
                next_ph1 = stg1;
                next_ph2 = stg2;
                next_ph3 = stg3;
                next_cyc = cyc_buf;
                next_half = half_buf;
            end
            next_p1 = cmp_cnt < ph1;
            next_p2 = cmp_cnt < ph2;
            next_p3 = cmp_cnt < ph3;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_a <= mpe_pkg::CNT_RST;
            cnt_b <= mpe_pkg::CNT_RST;
            sub_cnt <= mpe_pkg::CNT_RST;
            cyc <= mpe_pkg::CYCLE_RST;
            ph1 <= mpe_pkg::DUTY_RST;
            ph2 <= mpe_pkg::DUTY_RST;
            ph3 <= mpe_pkg::DUTY_RST;
            dead <= mpe_pkg::DEAD_RST;
            half <= mpe_pkg::HALF_RST;
            cyc_buf <= mpe_pkg::CYCLE_RST;
            ph1_buf <= mpe_pkg::DUTY_RST;
            ph2_buf <= mpe_pkg::DUTY_RST;
            ph3_buf <= mpe_pkg::DUTY_RST;
            half_buf <= mpe_pkg::HALF_RST;
            stg1 <= mpe_pkg::DUTY_RST;
            stg2 <= mpe_pkg::DUTY_RST;
            stg3 <= mpe_pkg::DUTY_RST;
            prot <= mpe_pkg::PROTECT_RST;
            dir_a_down <= 1'b0;
            dir_b_down <= 1'b0;
            tog <= 1'b0;
            p1 <= 1'b0;
            p2 <= 1'b0;
            p3 <= 1'b0;
            mode_q <= mpe_pkg::MPE_MODE_NORMAL;
        end else if (i_ce) begin
            cnt_a <= next_cnt_a;
            cnt_b <= next_cnt_b;
            sub_cnt <= next_sub_cnt;
            cyc <= next_cyc;
            ph1 <= next_ph1;
            ph2 <= next_ph2;
            ph3 <= next_ph3;
            dead <= next_dead;
            half <= next_half;
            cyc_buf <= next_cyc_buf;
            ph1_buf <= next_ph1_buf;
            ph2_buf <= next_ph2_buf;
            ph3_buf <= next_ph3_buf;
            half_buf <= next_half_buf;
            stg1 <= next_stg1;
            stg2 <= next_stg2;
            stg3 <= next_stg3;
            prot <= next_prot;
            dir_a_down <= next_dir_a_down;
            dir_b_down <= next_dir_b_down;
            tog <= next_tog;
            p1 <= next_p1;
            p2 <= next_p2;
            p3 <= next_p3;
            mode_q <= i_mode;
        end
    end

    logic pwm_on, dt_gap;
    always_comb begin
        pwm_on = rs | cp;
        // dead time gap: both sides low while a and b disagree on phase
        dt_gap = cp && i_dead_time_en && (sub_cnt != cnt_b);
    end
    assign o_pwm_pins_active = pwm_on;
    assign o_period_toggle_active = cp && i_period_toggle_en;
    assign o_period_toggle_out = tog;
    assign o_pwm1_pos_out = pwm_on & p1 & ~dt_gap;
    assign o_pwm1_neg_out = pwm_on & ~p1 & ~dt_gap;
    assign o_pwm2_pos_out = pwm_on & p2 & ~dt_gap;
    assign o_pwm2_neg_out = pwm_on & ~p2 & ~dt_gap;
    assign o_pwm3_pos_out = pwm_on & p3 & ~dt_gap;
    assign o_pwm3_neg_out = pwm_on & ~p3 & ~dt_gap;
    assign o_up_down_counter = enc_count;
    assign o_pulse_width_capture = pw_cap;
    assign o_pulse_width_capture_buffer = pw_buf;
    assign o_count_snapshot_a = snap_a;
    assign o_count_snapshot_b = snap_b;
    assign o_carrier_counter_a = cnt_a;
    assign o_carrier_counter_b = cnt_b;
    assign o_deadtime_subcounter = sub_cnt;
    assign o_cycle_limit_reg = cyc;
    assign o_phase1_compare = ph1;
    assign o_phase2_compare = ph2;
    assign o_phase3_compare = ph3;
    assign o_deadtime_value = dead;
    assign o_half_cycle_value = half;
    assign o_cycle_limit_buffer = cyc_buf;
    assign o_phase1_buffer = ph1_buf;
    assign o_phase2_buffer = ph2_buf;
    assign o_phase3_buffer = ph3_buf;
    assign o_half_cycle_buffer = half_buf;
    assign o_write_protect_reg = prot;

    property p_rs_clear;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && rs && i_start && !enter_cp && cnt_a == cyc) |=> cnt_a == 16'h0;
    endproperty
    a_rs_clear: assert property (p_rs_clear) else $error("no clear");
    property p_rs_tog;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && rs && i_start && clr_a && !m1) |=> p1 != $past(p1);
    endproperty
    a_rs_tog: assert property (p_rs_tog) else $error("no toggle");
    property p_prot;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !wr_ok && !cp && !rs && i_cycle_limit_we) |=> $stable(cyc);
    endproperty
    a_prot: assert property (p_prot) else $error("protected write");
    property p_enter;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && enter_cp) |=> (cyc == $past(cyc_buf)) && cnt_a == $past(dead)
            && cnt_b == 16'h0;
    endproperty
    a_enter: assert property (p_enter) else $error("bad entry load");
    property p_inv;
        @(posedge i_clk) disable iff (!i_rstn)
        rs |-> o_pwm1_neg_out == !o_pwm1_pos_out;
    endproperty
    a_inv: assert property (p_inv) else $error("not inverse");
    property p_buf;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_phase1_buf_we) |=> ph1_buf == $past(i_wdata);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer write lost");
    c_rs_clear: cover property (@(posedge i_clk) rs && clr_a);
    c_cp_turn: cover property (@(posedge i_clk) cp && i_start && dir_a_down);
    c_enc: cover property (@(posedge i_clk) enc_clk);
endmodule
`default_nettype wire

// *** tb/mpe_enc_model.sv ***
/*
 * mpe_enc_model: two-phase encoder that feeds the count inputs.
 * assumes the bench raises i_fwd or i_bwd for one clock per step.
 */
`default_nettype none
module mpe_enc_model (
    input wire logic i_clk,
    input wire logic i_fwd,
    input wire logic i_bwd,
    output logic o_a,
    output logic o_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph = 2'h0;
    // steps land on the falling edge, away from the block's sampling
    always @(negedge i_clk) begin
        if (i_fwd) ph <= ph + 2'h1;
        else if (i_bwd) ph <= ph - 2'h1;
    end
    // gray order: one pin moves per step, b leads a going forward, so
    // forward b edges count up in the b-edge-only count mode
    assign o_a = ph[1];
    assign o_b = ph[0] ^ ph[1];
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/*
 * testbench: self-checking bench for mpe_motor_timer.
 * assumes mpe_pkg and mpe_enc_model are compiled first.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rstn, i_ce, i_ovf_clr, i_unf_clr, i_start, fwd, bwd;
    logic i_write_protect_we, i_period_toggle_en, i_dead_time_en;
    logic i_capture_on_count_clk, i_capture_buffer_mode;
    logic [15:0] i_wdata, i_speed_period_compare, i_position_period_compare;
    logic [7:0] i_write_protect_wdata, o_write_protect_reg;
    logic [12:0] we;
    mpe_pkg::mpe_mode_t i_mode;
    wire logic i_enc_a_in_ch1, i_enc_b_in_ch1, i_cnt_a_we, i_cnt_b_we;
    wire logic i_cycle_limit_we, i_phase1_we, i_phase2_we, i_phase3_we;
    wire logic i_deadtime_we, i_half_cycle_we, i_cycle_buf_we;
    wire logic i_phase1_buf_we, i_phase2_buf_we, i_phase3_buf_we;
    wire logic i_half_buf_we;
    logic [15:0] o_up_down_counter, o_pulse_width_capture;
    logic [15:0] o_pulse_width_capture_buffer, o_count_snapshot_a;
    logic [15:0] o_count_snapshot_b, o_carrier_counter_a;
    logic [15:0] o_carrier_counter_b, o_deadtime_subcounter;
    logic [15:0] o_cycle_limit_reg, o_phase1_compare, o_phase2_compare;
    logic [15:0] o_phase3_compare, o_deadtime_value, o_half_cycle_value;
    logic [15:0] o_cycle_limit_buffer, o_phase1_buffer, o_phase2_buffer;
    logic [15:0] o_phase3_buffer, o_half_cycle_buffer, prev;
    logic o_overflow_flag, o_underflow_flag, o_pwm_pins_active;
    logic o_period_toggle_out, o_period_toggle_active, last;
    logic o_pwm1_pos_out, o_pwm1_neg_out, o_pwm2_pos_out, o_pwm2_neg_out;
    logic o_pwm3_pos_out, o_pwm3_neg_out;
    int err_total = 0;
    int tests_run = 0;
    int bad, hits, tg;
    assign {i_half_buf_we, i_phase3_buf_we, i_phase2_buf_we,
        i_phase1_buf_we, i_cycle_buf_we, i_half_cycle_we, i_deadtime_we,
        i_phase3_we, i_phase2_we, i_phase1_we, i_cycle_limit_we,
        i_cnt_b_we, i_cnt_a_we} = we;
    mpe_motor_timer u_mpe_motor_timer (.*);
    mpe_enc_model u_mpe_enc_model (.i_clk(i_clk), .i_fwd(fwd),
        .i_bwd(bwd), .o_a(i_enc_a_in_ch1), .o_b(i_enc_b_in_ch1));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // index: cnt_a cnt_b cycle p1 p2 p3 dead half cbuf p1b p2b p3b hbuf
    task automatic wr(int k, logic [15:0] d);
        @(posedge i_clk);
        we <= 13'h0001 << k;
        i_wdata <= d;
        @(posedge i_clk);
        we <= 13'h0000;
    endtask
    task automatic wp(logic [7:0] d);
        @(posedge i_clk);
        i_write_protect_wdata <= d;
        i_write_protect_we <= 1'b1;
        @(posedge i_clk);
        i_write_protect_we <= 1'b0;
    endtask
    task automatic step(logic f, int n);
        repeat (n) begin
            @(posedge i_clk);
            fwd <= f;
            bwd <= !f;
            @(posedge i_clk);
            fwd <= 1'b0;
            bwd <= 1'b0;
            repeat (8) @(posedge i_clk);
        end
        tick(1);
    endtask
    task automatic t_encoder;
        step(1'b1, 4);
        chk("count up", 16'h0002, o_up_down_counter);
        step(1'b0, 4);
        chk("count down", 16'h0000, o_up_down_counter);
        // first backward step from rest moves a only; the second moves b
        step(1'b0, 2);
        chk("wrap down", 16'hffff, o_up_down_counter);
        chk("underflow", 16'h0001, {15'h0, o_underflow_flag});
        step(1'b1, 2);
        chk("a edge ignored", 16'h0000, o_up_down_counter);
        chk("overflow", 16'h0001, {15'h0, o_overflow_flag});
    endtask
    task automatic t_protect;
        wp(8'h00);
        wr(2, 16'h0005);
        wr(8, 16'h0007);
        tick(1);
        chk("locked limit", 16'hffff, o_cycle_limit_reg);
        chk("open buffer", 16'h0007, o_cycle_limit_buffer);
        wp(8'h01);
    endtask
    task automatic t_reset_sync;
        wr(0, 16'h0000);
        wr(1, 16'h0000);
        wr(2, 16'h0009);
        wr(3, 16'h0003);
        wr(4, 16'h0005);
        wr(5, 16'h0007);
        @(posedge i_clk);
        i_mode <= mpe_pkg::MPE_MODE_RESET_SYNC;
        i_start <= 1'b1;
        tick(2);
        {bad, hits, prev, last} = {64'h0, o_carrier_counter_a, o_pwm1_pos_out};
        repeat (40) begin
            tick(1);
            chk("neg pairs", {13'h0, ~o_pwm1_pos_out, ~o_pwm2_pos_out,
                ~o_pwm3_pos_out}, {13'h0, o_pwm1_neg_out, o_pwm2_neg_out,
                o_pwm3_neg_out});
            if (o_carrier_counter_a !== prev + 16'h1 &&
                !(prev === 16'h9 && o_carrier_counter_a === 16'h0)) bad++;
            if (o_pwm1_pos_out !== last) hits++;
            {prev, last} = {o_carrier_counter_a, o_pwm1_pos_out};
        end
        chk("sawtooth", 16'h0000, 16'(bad));
        chk("toggles", 16'h0008, 16'(hits));
        chk("pins", 16'h0001, {15'h0, o_pwm_pins_active});
    endtask
    task automatic t_compl;
        @(posedge i_clk);
        i_start <= 1'b0;
        i_mode <= mpe_pkg::MPE_MODE_NORMAL;
        wr(8, 16'h0014);
        wr(12, 16'h0010);
        wr(6, 16'h0004);
        wr(9, 16'h0008);
        @(posedge i_clk);
        i_mode <= mpe_pkg::MPE_MODE_COMPL;
        tick(3);
        chk("a start", 16'h0004, o_carrier_counter_a);
        chk("b start", 16'h0000, o_carrier_counter_b);
        chk("limit load", 16'h0014, o_cycle_limit_reg);
        chk("half load", 16'h0010, o_half_cycle_value);
        // the spare pin is never routed to the timer here
        @(posedge i_clk);
        i_start <= 1'b1;
        {bad, hits, tg} = 96'h0;
        last = o_period_toggle_out;
        repeat (80) begin
            tick(1);
            if (o_carrier_counter_b !== o_carrier_counter_a - 16'h4) bad++;
            if (o_carrier_counter_a === 16'h0014) hits++;
            if (o_period_toggle_out !== last) tg++;
            last = o_period_toggle_out;
        end
        chk("offset", 16'h0000, 16'(bad));
        // a runs 4..20..4, a 32-cycle period: peaks at samples 16, 48, 80
        chk("peaks", 16'h0003, 16'(hits));
        // troughs at samples 32 and 64
        chk("period toggles", 16'h0002, 16'(tg));
        chk("toggle pin", 16'h0001, {15'h0, o_period_toggle_active});
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        {i_rstn, i_ovf_clr, i_unf_clr, i_start, fwd, bwd} = 6'h00;
        {i_ce, i_period_toggle_en, i_dead_time_en} = 3'h7;
        {i_capture_on_count_clk, i_capture_buffer_mode} = 2'h3;
        {i_write_protect_we, i_write_protect_wdata, we, i_wdata} = 38'h0;
        i_speed_period_compare = 16'h0040;
        i_position_period_compare = 16'h0080;
        i_mode = mpe_pkg::MPE_MODE_NORMAL;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_encoder;
        t_protect;
        t_reset_sync;
        t_compl;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire
